// ===== rtl/wdt_defs.svh
// Watchdog timer constants: register offsets, field positions, reset values and timing counts
//
// Contract
// - Count low-speed clock, timeout raises non-maskable request
// - Counter keeps running while CPU halts
// - Counter frozen while device sleeps
// - Request drives NMI level 4, unmaskable
// - Exception vector fetched from 000004H
// - Writing one to clear bit restarts count
// - Clear bit always reads back zero
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ==========================================================================
// Register map
`define WDT_ADDR_CTRL 16'hFF40
`define WDT_ADDR_STATUS 16'hFF48
`define WDT_ADDR_MASK 16'hFF49
`define WDT_ADDR_COUNT 16'hFF4A

// ==========================================================================
// Control register fields
`define WDT_CTRL_FSEL_LSB 4
`define WDT_CTRL_FSEL_MSB 6
`define WDT_CTRL_FOUT_ON 3
`define WDT_CTRL_CLEAR 2
`define WDT_CTRL_TMR_CLEAR 1
`define WDT_CTRL_TMR_RUN 0
`define WDT_CTRL_RW_MASK 8'h79
`define WDT_CTRL_RESET 8'h00

// ==========================================================================
// Status and mask fields
`define WDT_STAT_TIMEOUT 0
`define WDT_STAT_MASK 8'h01
`define WDT_STAT_RESET 8'h00
`define WDT_MASK_RESET 8'h00

// ==========================================================================
// Interrupt delivery
`define WDT_NMI_LEVEL 3'h4
`define WDT_NMI_VECTOR 24'h000004

// ==========================================================================
// Timing
`define WDT_CLK_HZ 250000000
`define WDT_LOW_OSC_HZ 32768
`define WDT_LOW_OSC_DIV (`WDT_CLK_HZ / `WDT_LOW_OSC_HZ)
`define WDT_TIMEOUT_MS 3500
`define WDT_CHAIN_W 17
`define WDT_TIMEOUT_TICKS ((`WDT_TIMEOUT_MS * `WDT_LOW_OSC_HZ) / 1000)
`define WDT_COUNT_VIEW_LSB 9

`endif

// ===== rtl/wdt_pkg.sv
// Watchdog timer shared types
package wdt_pkg;

  // ==========================================================================
  // Bus types
  typedef logic [15:0] wdt_addr_t;
  typedef logic [7:0] wdt_byte_t;

  // ==========================================================================
  // Watchdog sequencer states, Gray along run -> fire -> run
  typedef enum logic [1:0] {
    WDT_ST_RUN = 2'b00,
    WDT_ST_FIRE = 2'b01,
    WDT_ST_SLEEP = 2'b10
  } wdt_state_e;

endpackage

// ===== rtl/wdt_tick_gen.sv
// Low-speed oscillator tick: one-cycle enable pulse divided from the system clock
`timescale 1ns/1ps
module wdt_tick_gen #(
  parameter int DIV = 7629,
  parameter int DIV_W = 13
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic clr_i,
  // Tick
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // ==========================================================================
  // Divider: phase restarts with the chain so a clear gives a full first tick
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (clr_i) begin
      cnt_nxt = '0;
    end else if (run_i) begin
      if (cnt_r == DIV_W'(DIV - 1)) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + DIV_W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule // wdt_tick_gen

// ===== rtl/wdt_top.sv
// Watchdog timer with NMI request, register port and interrupt status
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top #(
  parameter int LOW_OSC_DIV = `WDT_LOW_OSC_DIV,
  parameter int TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS,
  parameter int CHAIN_W = `WDT_CHAIN_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire wdt_pkg::wdt_addr_t addr_i,
  input wire wdt_pkg::wdt_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output wdt_pkg::wdt_byte_t rdata_o,
  // CPU power states
  input wire logic halt_i,
  input wire logic sleep_i,
  // CPU non-maskable interrupt
  output logic nmi_o,
  output logic [2:0] nmi_level_o,
  output logic [23:0] nmi_vector_o,
  // Maskable event interrupt
  output logic irq_o
);
  import wdt_pkg::*;

  localparam int DIV_W = $clog2(LOW_OSC_DIV + 1);
  localparam logic [CHAIN_W-1:0] LAST_COUNT = CHAIN_W'(TIMEOUT_TICKS - 1);

  // ==========================================================================
  // Behaviour in brief
  // One low-speed tick every LOW_OSC_DIV system cycles advances the chain by one.
  // The chain fires at its terminal count, then restarts, so a lost program
  // sees a request once per timeout period until it clears the chain again.
  // Limitation: a tick that lands in the cycle in which sleep rises is dropped,
  // so each sleep entry may give back up to one low-speed period of slack.
  // A clear restarts both the divider phase and the chain, so the next timeout
  // is a full period away whatever the phase was at the time of the clear.

  // ==========================================================================
  // Functions
  // Address compare used by both the write and the read path
  function automatic logic hit(input wdt_addr_t a, input wdt_addr_t reg_addr);
    hit = (a == reg_addr);
  endfunction

  // Terminal count of the chain at the timeout tap
  function automatic logic at_tap(input logic [CHAIN_W-1:0] c);
    at_tap = (c == LAST_COUNT);
  endfunction

  // ==========================================================================
  // Reset synchroniser: asynchronous assert, two-flop release
  // Release waits two edges so no flop leaves reset on a metastable edge
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Register port decode
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic clear_req;

  // Writes never stall; unmapped writes are dropped
  // Both strobes at once is not a legal bus cycle; write decode ignores rd_i
  always_comb begin
    wr_ctrl = wr_i && hit(addr_i, `WDT_ADDR_CTRL);
    wr_status = wr_i && hit(addr_i, `WDT_ADDR_STATUS);
    wr_mask = wr_i && hit(addr_i, `WDT_ADDR_MASK);
    clear_req = wr_ctrl && wdata_i[`WDT_CTRL_CLEAR];
  end

  // ==========================================================================
  // Low-speed tick source
  logic run_en;
  logic tick;

  // Halt does not enter here, so the watchdog keeps counting through it
  // Sleep gates the divider too, so its phase is held rather than lost
  assign run_en = !sleep_i;

  wdt_tick_gen #(
    .DIV(LOW_OSC_DIV),
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .run_i(run_en),
    .clr_i(clear_req),
    .tick_o(tick)
  );

  // ==========================================================================
  // Divider chain and sequencer
  logic [CHAIN_W-1:0] chain_r;
  logic [CHAIN_W-1:0] chain_nxt;
  wdt_state_e state_r;
  wdt_state_e state_nxt;
  logic nmi_r;
  logic nmi_nxt;
  logic timeout_evt;

  // A clear in the same cycle as the terminal tick wins: no NMI is raised
  // Clear has priority over sleep so software can restart the chain on the way in
  always_comb begin
    chain_nxt = chain_r;
    state_nxt = state_r;
    nmi_nxt = 1'b0;
    timeout_evt = 1'b0;
    unique case (state_r)
      WDT_ST_RUN: begin
        if (clear_req) begin
          chain_nxt = '0;
        end else if (sleep_i) begin
          state_nxt = WDT_ST_SLEEP;
        end else if (tick) begin
          if (at_tap(chain_r)) begin
            chain_nxt = '0;
            state_nxt = WDT_ST_FIRE;
            nmi_nxt = 1'b1;
            timeout_evt = 1'b1;
          end else begin
            chain_nxt = chain_r + CHAIN_W'(1);
          end
        end
      end
      WDT_ST_FIRE: begin
        // Chain restarts, so an ignored watchdog repeats its request
        if (clear_req) begin
          chain_nxt = '0;
        end
        state_nxt = sleep_i ? WDT_ST_SLEEP : WDT_ST_RUN;
      end
      WDT_ST_SLEEP: begin
        // Count is held, only a clear may still change it
        if (clear_req) begin
          chain_nxt = '0;
        end
        if (!sleep_i) begin
          state_nxt = WDT_ST_RUN;
        end
      end
      default: begin
        chain_nxt = '0;
        state_nxt = WDT_ST_RUN;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      chain_r <= '0;
      state_r <= WDT_ST_RUN;
      nmi_r <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
      state_r <= state_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  // ==========================================================================
  // Control register: stored fields read back, strobes read zero
  wdt_byte_t ctrl_r;
  wdt_byte_t ctrl_nxt;

  // Stored fields have no function here; the strobe bits are masked out
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wdata_i & `WDT_CTRL_RW_MASK;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r <= `WDT_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================================
  // Event status and mask
  wdt_byte_t status_r;
  wdt_byte_t status_nxt;
  wdt_byte_t mask_r;
  wdt_byte_t mask_nxt;
  logic irq_r;
  logic irq_nxt;

  // Write one to clear; a timeout in the clearing cycle stays set
  always_comb begin
    status_nxt = status_r;
    mask_nxt = mask_r;
    if (wr_status) begin
      status_nxt = status_r & ~(wdata_i & `WDT_STAT_MASK);
    end
    if (timeout_evt) begin
      status_nxt[`WDT_STAT_TIMEOUT] = 1'b1;
    end
    if (wr_mask) begin
      mask_nxt = wdata_i & `WDT_STAT_MASK;
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      status_r <= `WDT_STAT_RESET;
      mask_r <= `WDT_MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================================
  // Read path: data valid only in the cycle after the read strobe
  wdt_byte_t rdata_r;
  wdt_byte_t rdata_nxt;

  // Unmapped addresses and idle cycles return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
      if (hit(addr_i, `WDT_ADDR_CTRL)) begin
        rdata_nxt = ctrl_r;
      end else if (hit(addr_i, `WDT_ADDR_STATUS)) begin
        rdata_nxt = status_r;
      end else if (hit(addr_i, `WDT_ADDR_MASK)) begin
        rdata_nxt = mask_r;
      end else if (hit(addr_i, `WDT_ADDR_COUNT)) begin
        rdata_nxt = chain_r[`WDT_COUNT_VIEW_LSB +: 8];
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // NMI delivery: level and vector are fixed, no mask ever touches nmi_o
  logic [2:0] level_r;
  logic [2:0] level_nxt;
  logic [23:0] vector_r;
  logic [23:0] vector_nxt;

  // Held in flops so every top output comes from a register, at no timing cost
  always_comb begin
    level_nxt = `WDT_NMI_LEVEL;
    vector_nxt = `WDT_NMI_VECTOR;
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      level_r <= `WDT_NMI_LEVEL;
      vector_r <= `WDT_NMI_VECTOR;
    end else begin
      level_r <= level_nxt;
      vector_r <= vector_nxt;
    end
  end

  // Outputs, all from flip-flops
  assign rdata_o = rdata_r;
  assign nmi_o = nmi_r;
  assign nmi_level_o = level_r;
  assign nmi_vector_o = vector_r;
  assign irq_o = irq_r;

  // halt_i is listed for completeness; counting ignores it by design
  logic unused_halt;
  assign unused_halt = halt_i;

endmodule // wdt_top

// ===== verification/tb_top.sv
// Self-checking testbench for the watchdog timer
`timescale 1ns/1ps
`include "wdt_defs.svh"
module tb_top;
  import wdt_pkg::*;
  localparam int DIV = 4;
  localparam int TT = 8;
  localparam int LIM = (TT + 2) * DIV;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  wdt_addr_t addr_i = 16'h0000;
  wdt_byte_t wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic halt_i = 1'b0;
  logic sleep_req = 1'b0;
  wdt_byte_t rdata_o;
  logic sleep_i;
  logic nmi_o;
  logic irq_o;
  logic bad;
  logic [2:0] nmi_level_o;
  logic [23:0] nmi_vector_o;
  logic [7:0] n_nmi;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  // ==========================================================================
  // Design and CPU model, with short counts to keep the run brief
  wdt_top #(.LOW_OSC_DIV(DIV), .TIMEOUT_TICKS(TT), .CHAIN_W(17)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i),
    .sleep_i(sleep_i), .nmi_o(nmi_o), .nmi_level_o(nmi_level_o),
    .nmi_vector_o(nmi_vector_o), .irq_o(irq_o));
  wdt_cpu_mdl #(.GUARD(16)) cpu (
    .clk_i(clk_i), .resetn_i(resetn_i), .nmi_i(nmi_o), .nmi_level_i(nmi_level_o),
    .nmi_vector_i(nmi_vector_o), .sleep_req_i(sleep_req), .sleep_o(sleep_i),
    .nmi_cnt_o(n_nmi), .bad_o(bad));
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  // Hang guard: the sequence needs about 520 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input wdt_addr_t a, input wdt_byte_t d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input wdt_addr_t a, input wdt_byte_t e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  // Bounded wait; the pulse is one cycle, so it is sampled mid-cycle
  task automatic wait_nmi(input int lim);
    int n;
    n = 0;
    while (nmi_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk({7'h00, nmi_o}, 8'h01);
  endtask
  // Clears spaced well inside the timeout
  task automatic keep(input int k);
    repeat (k) begin
      wr(`WDT_ADDR_CTRL, 8'h04);
      repeat (4 * DIV) @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`WDT_ADDR_CTRL, 8'h00);
    rd(`WDT_ADDR_STATUS, 8'h00);
    rd(`WDT_ADDR_MASK, 8'h00);
    // Count view shows the top chain bits, zero with this short timeout
    rd(`WDT_ADDR_COUNT, 8'h00);
    wr(`WDT_ADDR_CTRL, 8'hFF);
    rd(`WDT_ADDR_CTRL, `WDT_CTRL_RW_MASK);
    wr(16'hFF41, 8'hFF);
    rd(16'hFF41, 8'h00);
    wr(`WDT_ADDR_MASK, 8'h01);
    halt_i <= 1'b1;
    keep(12);
    chk(n_nmi, 8'h00);
    // Writing zero must not restart, so the request comes early
    wr(`WDT_ADDR_CTRL, 8'h00);
    wait_nmi(20);
    @(negedge clk_i);
    chk({7'h00, irq_o}, 8'h01);
    rd(`WDT_ADDR_STATUS, 8'h01);
    wr(`WDT_ADDR_CTRL, 8'h04);
    wr(`WDT_ADDR_STATUS, 8'h01);
    rd(`WDT_ADDR_STATUS, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    // Mask only gates irq_o, never the request itself
    wr(`WDT_ADDR_MASK, 8'h00);
    wait_nmi(LIM);
    // The model counts the request only at the next rising edge
    @(negedge clk_i);
    @(negedge clk_i);
    chk(n_nmi, 8'h02);
    chk({7'h00, irq_o}, 8'h00);
    @(posedge clk_i);
    sleep_req <= 1'b1;
    #1;
    chk({7'h00, sleep_i}, 8'h00);
    repeat (200) @(posedge clk_i);
    chk({7'h00, sleep_i}, 8'h01);
    chk(n_nmi, 8'h02);
    sleep_req <= 1'b0;
    wait_nmi(LIM);
    chk({7'h00, bad}, 8'h00);
    chk({5'h00, nmi_level_o}, 8'h04);
    close_out();
  end
endmodule // tb_top

// ===== verification/wdt_chk.sv
// Port-level assertion checker for the watchdog timer
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_chk #(
  parameter int LOW_OSC_DIV = 4,
  parameter int TIMEOUT_TICKS = 8,
  parameter int CHAIN_W = 17
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire wdt_pkg::wdt_addr_t addr_i,
  input wire wdt_pkg::wdt_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire wdt_pkg::wdt_byte_t rdata_o,
  // Power states and interrupts
  input wire logic halt_i,
  input wire logic sleep_i,
  input wire logic nmi_o,
  input wire logic [2:0] nmi_level_o,
  input wire logic [23:0] nmi_vector_o,
  input wire logic irq_o
);
  import wdt_pkg::*;
  // ==========================================================================
  // Live counting since the last restart
  // Slack of a few cycles covers the reset synchroniser and tick phase
  localparam int LoBound = (TIMEOUT_TICKS - 1) * LOW_OSC_DIV;
  localparam int HiBound = (TIMEOUT_TICKS + 1) * LOW_OSC_DIV + 4;
  logic clr_w;
  int run_r;
  int run_nxt;
  assign clr_w = wr_i && addr_i == `WDT_ADDR_CTRL && wdata_i[`WDT_CTRL_CLEAR];
  // Sleep freezes this count just as it freezes the chain
  always_comb begin
    run_nxt = run_r;
    if (clr_w || nmi_o) run_nxt = 0;
    else if (!sleep_i) run_nxt = run_r + 1;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) run_r <= 0;
    else run_r <= run_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_nmi_level: assert property (nmi_level_o == `WDT_NMI_LEVEL)
    else $error("nmi level is not four");
  chk_nmi_vector: assert property (nmi_vector_o == `WDT_NMI_VECTOR)
    else $error("nmi vector is wrong");
  chk_nmi_pulse: assert property (nmi_o |=> !nmi_o)
    else $error("nmi longer than one cycle");
  chk_no_early: assert property (nmi_o |-> run_r >= LoBound)
    else $error("nmi before the timeout");
  chk_late_bound: assert property (run_r <= HiBound)
    else $error("no nmi after the timeout");
  chk_sleep_hold: assert property (sleep_i && $past(sleep_i) |-> !nmi_o)
    else $error("nmi while asleep");
  chk_irq_cause: assert property ($rose(irq_o) |-> nmi_o || $past(wr_i))
    else $error("irq rose without cause");
  chk_clear_reads: assert property (rd_i && addr_i == `WDT_ADDR_CTRL |=> !rdata_o[2])
    else $error("clear bit read as one");
endmodule // wdt_chk

bind wdt_top wdt_chk #(
  .LOW_OSC_DIV(LOW_OSC_DIV),
  .TIMEOUT_TICKS(TIMEOUT_TICKS),
  .CHAIN_W(CHAIN_W)
) u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .halt_i(halt_i),
  .sleep_i(sleep_i),
  .nmi_o(nmi_o),
  .nmi_level_o(nmi_level_o),
  .nmi_vector_o(nmi_vector_o),
  .irq_o(irq_o)
);

// ===== verification/wdt_cpu_mdl.sv
// CPU side model: takes watchdog requests and holds off sleep after one
`timescale 1ns/1ps
module wdt_cpu_mdl #(
  parameter int GUARD = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Watchdog request
  input wire logic nmi_i,
  input wire logic [2:0] nmi_level_i,
  input wire logic [23:0] nmi_vector_i,
  // Sleep control
  input wire logic sleep_req_i,
  output logic sleep_o,
  // Observation
  output logic [7:0] nmi_cnt_o,
  output logic bad_o
);
  int hold_r;
  // ==========================================================================
  // Each request must come at level 4 with vector 000004H, else it is flagged
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nmi_cnt_o <= 8'h00;
      bad_o <= 1'b0;
      hold_r <= 0;
    end else if (nmi_i) begin
      nmi_cnt_o <= nmi_cnt_o + 8'h01;
      bad_o <= bad_o | (nmi_level_i != 3'h4) | (nmi_vector_i != 24'h000004);
      hold_r <= GUARD;
    end else if (hold_r > 0) begin
      hold_r <= hold_r - 1;
    end
  end
  // Sleep waits out the guard, shortened from 2 ms to keep the run brief
  assign sleep_o = sleep_req_i && hold_r == 0;
endmodule // wdt_cpu_mdl
